/* File: include/spi_adc_cfg.svh */
// constants for the serial register port of the sensor die
`ifndef SPI_ADC_CFG_SVH
`define SPI_ADC_CFG_SVH

// header byte layout
`define HDR_RW_BIT 7
`define HDR_ADDR_MSB 4
`define HDR_ADDR_LSB 0
`define CMD_WRITE 1'h0
`define CMD_READ 1'h1

// byte framing
`define BYTE_BITS 8
`define BIT_CNT_LAST 3'h7

// result registers
`define ADDR_CURRENT_HIGH 5'h00
`define ADDR_CURRENT_LOW 5'h01
`define ADDR_VOLTAGE_HIGH 5'h02
`define ADDR_VOLTAGE_LOW 5'h03
`define RESULT_REG_COUNT 4
`define RESULT_RESET 8'h00
`define UNMAPPED_READ 8'h00

// index of each pin inside the synchroniser vector
`define PIN_SDI 0
`define PIN_SEL_N 1
`define PIN_SCLK 2
`define PIN_COUNT 3

`endif

/* File: include/spi_adc_pkg.sv */
// types for the serial register port of the sensor die
package spi_adc_pkg;

    // first byte of every frame, most significant bit first
    typedef struct packed {
        logic read_write_flag;
        logic [1:0] reserved;
        logic [4:0] register_address_field;
    } header_type;

    typedef enum logic [1:0] {
        IDLE_ST = 2'b00,
        HEADER_ST = 2'b01,
        DATA_ST = 2'b10
    } frame_state_type;

    // one conversion result and its load strobe
    typedef struct packed {
        logic [15:0] value;
        logic valid;
    } result_type;

endpackage

/* File: verilog/spi_adc_regs.sv */
// serial register port giving the master access to the adc result bytes
`timescale 1ns/1ns
`include "spi_adc_cfg.svh"
//
// What this block does
// - first byte: command, two reserved, 5-bit address
// - rest of frame is whole data bytes
// - command 0 takes data bytes but stores none
// - command 1 returns register at start address
// - address advances per further byte, both directions
// - write bits driven on transfer edge, sampled next
// - read data shifted out msb first
// - read data driven by device on transfer edge
// - current result bytes at 00 and 01
// - voltage result bytes at 02 and 03
// - sclk level at select fall picks edges
module spi_adc_regs (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // serial link pins
    input wire logic SCLK,
    input wire logic SENSOR_DIE_SELECT_N,
    input wire logic SDI,
    output logic SDO,
    output logic SDO_OE,
    // conversion results from the on-die filters
    input wire spi_adc_pkg::result_type CURRENT_RESULT,
    input wire spi_adc_pkg::result_type VOLTAGE_RESULT
);

    // pin synchronisers; stage one is read only by stage two
    logic [`PIN_COUNT-1:0] pin_meta_q;
    logic [`PIN_COUNT-1:0] pin_sync_q;
    logic [`PIN_COUNT-1:0] pin_prev_q;
    logic [`PIN_COUNT-1:0] pin_raw;

    assign pin_raw = {SCLK, SENSOR_DIE_SELECT_N, SDI};

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_meta_q <= 3'h6;
            pin_sync_q <= 3'h6;
            pin_prev_q <= 3'h6;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    logic sclk_level;
    logic sdi_level;
    logic selected;
    logic select_fall;
    logic sclk_rise;
    logic sclk_fall;

    assign sclk_level = pin_sync_q[`PIN_SCLK];
    assign sdi_level = pin_sync_q[`PIN_SDI];
    assign selected = ~pin_sync_q[`PIN_SEL_N];
    assign select_fall = pin_prev_q[`PIN_SEL_N] & ~pin_sync_q[`PIN_SEL_N];
    assign sclk_rise = sclk_level & ~pin_prev_q[`PIN_SCLK];
    assign sclk_fall = ~sclk_level & pin_prev_q[`PIN_SCLK];

    // clock polarity, caught once per frame
    logic falling_transfer_q;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            falling_transfer_q <= 1'b0;
        end else if (select_fall) begin
            falling_transfer_q <= sclk_level;
        end
    end

    // edges are not trusted in the select-fall cycle itself, polarity is not yet known there
    logic sample_edge;
    logic transfer_edge;

    assign sample_edge = selected & ~select_fall & (falling_transfer_q ? sclk_rise : sclk_fall);
    assign transfer_edge = selected & ~select_fall & (falling_transfer_q ? sclk_fall : sclk_rise);

    // result registers, loaded whole from each conversion
    logic [7:0] result_q [`RESULT_REG_COUNT];

    genvar idx;
    generate
        for (idx = 0; idx < `RESULT_REG_COUNT; idx++) begin : g_result
            // even index is the upper byte; first pair is current, second pair voltage
            spi_adc_pkg::result_type src;
            assign src = (idx < 2) ? CURRENT_RESULT : VOLTAGE_RESULT;

            always_ff @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    result_q[idx] <= `RESULT_RESET;
                end else if (src.valid) begin
                    result_q[idx] <= (idx % 2 == 0) ? src.value[15:8] : src.value[7:0];
                end
            end
        end
    endgenerate

    function automatic logic [7:0] read_byte(input logic [4:0] addr);
        logic [7:0] val;
        val = `UNMAPPED_READ;
        unique case (addr)
            `ADDR_CURRENT_HIGH: val = result_q[0];
            `ADDR_CURRENT_LOW: val = result_q[1];
            `ADDR_VOLTAGE_HIGH: val = result_q[2];
            `ADDR_VOLTAGE_LOW: val = result_q[3];
            default: val = `UNMAPPED_READ;
        endcase
        return val;
    endfunction

    // frame sequencing
    spi_adc_pkg::frame_state_type state_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] rx_q;
    logic is_read_q;
    logic [4:0] addr_q;
    logic byte_done;
    spi_adc_pkg::header_type header;

    assign byte_done = sample_edge && (bit_cnt_q == `BIT_CNT_LAST);
    assign header = spi_adc_pkg::header_type'({rx_q[6:0], sdi_level});

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= spi_adc_pkg::IDLE_ST;
        end else if (!selected) begin
            state_q <= spi_adc_pkg::IDLE_ST;
        end else if (select_fall) begin
            state_q <= spi_adc_pkg::HEADER_ST;
        end else if (byte_done && state_q == spi_adc_pkg::HEADER_ST) begin
            state_q <= spi_adc_pkg::DATA_ST;
        end
    end

    // bits shift in msb first, whether header or write data
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            bit_cnt_q <= 3'h0;
            rx_q <= 8'h00;
        end else if (!selected || select_fall) begin
            bit_cnt_q <= 3'h0;
            rx_q <= 8'h00;
        end else if (sample_edge) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            rx_q <= {rx_q[6:0], sdi_level};
        end
    end

    // header decode and auto increment; reserved bits are dropped here
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            is_read_q <= 1'b0;
            addr_q <= 5'h00;
        end else if (byte_done) begin
            unique case (state_q)
                spi_adc_pkg::HEADER_ST: begin
                    is_read_q <= (header.read_write_flag == `CMD_READ);
                    addr_q <= header.register_address_field;
                end
                spi_adc_pkg::DATA_ST: begin
                    addr_q <= addr_q + 5'h01;
                end
                default: begin
                    addr_q <= addr_q;
                end
            endcase
        end
    end

    // a completed write byte lands nowhere: every mapped register is read-only,
    // and the unmapped addresses belong to logic outside this block
    logic write_byte_done;
    assign write_byte_done = byte_done && state_q == spi_adc_pkg::DATA_ST && !is_read_q;

    // read path: next byte is fetched on the last sample edge so it is ready for the transfer edge
    logic [7:0] tx_q;
    logic [4:0] fetch_addr;

    assign fetch_addr = (state_q == spi_adc_pkg::HEADER_ST) ? header.register_address_field
                                                            : addr_q + 5'h01;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_q <= 8'h00;
        end else if (!selected) begin
            tx_q <= 8'h00;
        end else if (byte_done && !write_byte_done) begin
            tx_q <= read_byte(fetch_addr);
        end else if (transfer_edge && state_q == spi_adc_pkg::DATA_ST && is_read_q) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // the pin only turns on at the first data transfer edge of a read
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SDO <= 1'b0;
            SDO_OE <= 1'b0;
        end else if (!selected || state_q != spi_adc_pkg::DATA_ST || !is_read_q) begin
            SDO <= 1'b0;
            SDO_OE <= 1'b0;
        end else if (transfer_edge) begin
            SDO <= tx_q[7];
            SDO_OE <= 1'b1;
        end
    end

endmodule // spi_adc_regs

/* File: verif/spi_adc_regs_props.sv */
// assertions on the sensor die serial register port
`timescale 1ns/1ns
module spi_adc_regs_props (
    // watched pins
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic SCLK,
    input wire logic SENSOR_DIE_SELECT_N,
    input wire logic SDI,
    input wire logic SDO,
    input wire logic SDO_OE
);
    logic sclk_q;
    logic rw_q;
    logic [7:0] edges_q;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // raw pin edges since select fell; runs ahead of the design's synchroniser
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sclk_q <= 1'b0;
            edges_q <= 8'h00;
            rw_q <= 1'b0;
        end else begin
            sclk_q <= SCLK;
            edges_q <= SENSOR_DIE_SELECT_N ? 8'h00 : edges_q + {7'h00, SCLK != sclk_q};
            // command bit rides on the first link edge after select falls
            if (!SENSOR_DIE_SELECT_N && edges_q == 8'h00 && SCLK != sclk_q) begin
                rw_q <= SDI;
            end
        end
    end
    chk_sdo_parked: assert property (!SDO_OE |-> !SDO) else $error("sdo not parked");
    chk_idle_off: assert property (SENSOR_DIE_SELECT_N [*5] |-> !SDO_OE) else $error("sdo on idle");
    chk_oe_drop: assert property ($rose(SENSOR_DIE_SELECT_N) |-> ##[1:5] !SDO_OE) else $error("oe late");
    chk_oe_holds: assert property ($fell(SDO_OE) |-> $past(SENSOR_DIE_SELECT_N, 2)) else $error("oe cut");
    chk_oe_steady: assert property (SDO_OE && !$past(SENSOR_DIE_SELECT_N, 2) |=> SDO_OE) else $error("oe gap");
    chk_sdo_edge: assert property (SDO_OE && $changed(SDO) |-> $past(SCLK, 2) != $past(SCLK, 5))
        else $error("sdo off edge");
    chk_oe_edge: assert property ($rose(SDO_OE) |-> $past(SCLK, 2) != $past(SCLK, 5)) else $error("oe off edge");
    chk_oe_first_data: assert property ($rose(SDO_OE) |-> edges_q == 8'h11 && !SENSOR_DIE_SELECT_N)
        else $error("oe in header");
    chk_write_quiet: assert property ($rose(SDO_OE) |-> rw_q) else $error("sdo on in write");
endmodule // spi_adc_regs_props
bind spi_adc_regs spi_adc_regs_props u_props (.CLK(CLK), .RESET_N(RESET_N), .SCLK(SCLK),
    .SENSOR_DIE_SELECT_N(SENSOR_DIE_SELECT_N), .SDI(SDI), .SDO(SDO), .SDO_OE(SDO_OE));

/* File: verif/spi_master_model.sv */
// serial master standing in for the microcontroller
`timescale 1ns/1ns
module spi_master_model (
    // serial link pins
    output logic sclk,
    output logic sel_n,
    output logic sdi,
    input wire logic sdo
);
    initial begin
        sclk = 1'b0;
        sel_n = 1'b1;
        sdi = 1'b0;
    end
    // one frame; wd left aligned, rd right aligned
    task automatic frame(input logic pol, input logic [7:0] hdr, input int n, input logic [31:0] wd,
        output logic [31:0] rd);
        logic [39:0] sh;
        sh = {hdr, wd};
        rd = 32'h0;
        sclk = pol;
        #40 sel_n = 1'b0;
        #80;
        for (int i = 0; i < 8 * n + 8; i++) begin
            sclk = ~pol;
            sdi = sh[39 - i];
            #80 sclk = pol;
            if (i > 7) rd = {rd[30:0], sdo};
            #80;
        end
        sel_n = 1'b1;
        // a released line must not keep showing the last bit
        sdi = ~sdi;
    endtask
endmodule // spi_master_model

/* File: verif/spi_adc_regs_test.sv */
// self-checking bench for the sensor die serial register port
`timescale 1ns/1ns
module spi_adc_regs_test;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic sclk, sel_n, sdi, sdo, sdo_oe;
    spi_adc_pkg::result_type cur = 17'h00000;
    spi_adc_pkg::result_type volt = 17'h00000;
    int fails = 0;
    int num_checks = 0;
    logic [31:0] rd;
    wire sdo_wire = sdo_oe ? sdo : 1'bz;
    always #5 clk = ~clk;
    spi_adc_regs dut (.CLK(clk), .RESET_N(reset_n), .SCLK(sclk), .SENSOR_DIE_SELECT_N(sel_n), .SDI(sdi),
        .SDO(sdo), .SDO_OE(sdo_oe), .CURRENT_RESULT(cur), .VOLTAGE_RESULT(volt));
    spi_master_model m (.sclk(sclk), .sel_n(sel_n), .sdi(sdi), .sdo(sdo_wire));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic load(input logic [15:0] c, input logic [15:0] v);
        @(posedge clk) #1;
        cur = {c, 1'b1};
        volt = {v, 1'b1};
        @(posedge clk) #1;
        cur.valid = 1'b0;
        volt.valid = 1'b0;
    endtask
    // writes are checked by the read that follows them
    task automatic xfer(input logic pol, input logic [7:0] hdr, input int n, input logic [31:0] wd,
        input logic [31:0] exp);
        @(posedge clk) #1;
        m.frame(pol, hdr, n, wd, rd);
        repeat (8) @(posedge clk);
        if (hdr[7]) check(rd, exp);
        check({31'h0, sdo_oe}, 32'h0);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge clk);
        xfer(1'b0, 8'h80, 4, 32'h0, 32'h0);
        load(16'hA55A, 16'h3CC3);
        xfer(1'b1, 8'hE0, 4, 32'h0, 32'hA55A3CC3);
        xfer(1'b0, 8'h61, 2, 32'h12340000, 32'h0);
        xfer(1'b1, 8'h81, 1, 32'h0, 32'h5A);
        xfer(1'b0, 8'h83, 2, 32'h0, 32'hC300);
        xfer(1'b1, 8'h9F, 2, 32'h0, 32'hA5);
        test_done;
    end
    initial begin
        #300000;
        fails++;
        test_done;
    end
endmodule // spi_adc_regs_test
